//--- core/tec_top.sv
// Trigger, exposure and readout framing with AHB-Lite registers
`timescale 1ns/10ps
`default_nettype none
`include "tec_consts.svh"
module tec_top #(
  parameter int          SENSOR_ROWS = 1024,
  parameter int          LINE_CYC    = 64,
  parameter int          GAP_CYC     = 8,
  parameter logic [31:0] EXP_RESET   = 32'(`TEC_EXP_RST_CYC)
) (
  input  wire logic        mclk,      // System clock, 20 MHz
  input  wire logic        rstn,      // Asynchronous reset, active low
  input  wire logic        hsel,      // AHB slave select
  input  wire logic [31:0] haddr,     // AHB address
  input  wire logic [1:0]  htrans,    // AHB transfer type
  input  wire logic        hwrite,    // AHB write
  input  wire logic [2:0]  hsize,     // AHB size, word only
  input  wire logic [31:0] hwdata,    // AHB write data
  input  wire logic        hready,    // AHB bus ready
  output logic             hreadyout, // AHB slave ready
  output logic [31:0]      hrdata,    // AHB read data
  output logic             hresp,     // AHB response
  input  wire logic        trig_in,   // External trigger
  input  wire logic        nv_valid,  // Stored exposure is present
  input  wire logic [31:0] nv_exp,    // Stored exposure value
  output var tec_pkg::tec_nv_t nv_out,  // Store request to NV memory
  output logic             exposing,  // Sensor integrating
  output var tec_pkg::tec_video_t video // Readout framing
);
  initial begin
    if (SENSOR_ROWS < 1 || SENSOR_ROWS > 65535 || LINE_CYC < 1 ||
        LINE_CYC > 65535 || GAP_CYC < 1 || GAP_CYC > 65535)
      $error("tec_top: unsupported geometry");
  end

  ////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  logic        ap_wr_q;
  logic [7:0]  ap_ofs_q;
  logic [31:0] ctrl_q;
  logic [31:0] exp_q;
  logic [31:0] roi_q;
  logic [31:0] rdata_q;
  logic        boot_q;
  logic        swtrig_q;
  logic        nvst_q;
  logic [15:0] frames_q;
  logic [31:0] status;
  logic [31:0] rd_mux;
  logic        ap_take;
  logic        wr_ctrl;
  logic        wr_exp;
  logic        wr_roi;
  logic        wr_sw;
  logic        wr_nv;

  assign ap_take   = hsel && hready && (htrans == `TEC_HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp     = `TEC_HRESP_OKAY;
  assign hrdata    = rdata_q;
  assign wr_ctrl   = ap_wr_q && (ap_ofs_q == `TEC_OFS_CTRL);
  assign wr_exp    = ap_wr_q && (ap_ofs_q == `TEC_OFS_EXP);
  assign wr_roi    = ap_wr_q && (ap_ofs_q == `TEC_OFS_ROI);
  assign wr_sw     = ap_wr_q && (ap_ofs_q == `TEC_OFS_SWTRIG);
  assign wr_nv     = ap_wr_q && (ap_ofs_q == `TEC_OFS_NVCMD);

  // Unmapped and write-only offsets read as zero
  assign rd_mux =
    (haddr[7:0] == `TEC_OFS_CTRL)   ? ctrl_q :
    (haddr[7:0] == `TEC_OFS_EXP)    ? exp_q  :
    (haddr[7:0] == `TEC_OFS_ROI)    ? roi_q  :
    (haddr[7:0] == `TEC_OFS_STATUS) ? status : 32'h0000_0000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ap_wr_q  <= 1'b0;
      ap_ofs_q <= 8'h00;
      rdata_q  <= 32'h0000_0000;
    end else begin
      ap_wr_q  <= ap_take && hwrite && (haddr[31:8] == 24'h00_0000);
      ap_ofs_q <= haddr[7:0];
      if (ap_take && !hwrite) rdata_q <= rd_mux;
    end
  end

  // Exposure is restored once, right after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= `TEC_CTRL_RST;
      exp_q    <= 32'h0000_0000;
      roi_q    <= `TEC_ROI_RST;
      boot_q   <= 1'b1;
      swtrig_q <= 1'b0;
      nvst_q   <= 1'b0;
    end else begin
      boot_q   <= 1'b0;
      swtrig_q <= wr_sw && hwdata[0];
      nvst_q   <= wr_nv && hwdata[0];
      if (boot_q) exp_q <= nv_valid ? nv_exp : EXP_RESET;
      else if (wr_exp) exp_q <= hwdata;
      if (wr_ctrl) ctrl_q <= hwdata;
      if (wr_roi) roi_q <= hwdata;
    end
  end

  assign nv_out = '{store: nvst_q, data: exp_q};

  ////////////////////////////////////////////////////////////////////
  // Exposure sequencer
  tec_pkg::tec_ex_state_t ex_q;
  tec_pkg::tec_ex_state_t ex_d;
  tec_pkg::tec_rd_state_t rd_q;
  logic [1:0]  mode;
  logic        en;
  logic        trig_q;
  logic        rise;
  logic        lval_fall;
  logic        lval_p_q;
  logic        start_req;
  logic        exp_end;
  logic        rd_start;
  logic        rd_busy;
  logic        tmr_load;
  logic        tmr_done;
  logic [31:0] tmr_val;
  logic [31:0] exp_act_q;

  assign mode      = ctrl_q[`TEC_CTRL_MODE_HI:`TEC_CTRL_MODE_LO];
  assign en        = ctrl_q[`TEC_CTRL_EN];
  assign rise      = trig_in && !trig_q;
  assign lval_fall = lval_p_q && !video.lval;
  assign rd_busy   = (rd_q != tec_pkg::RD_IDLE);
  // Software trigger shares the path of the pin; it carries bus jitter
  assign start_req = en && (ex_q == tec_pkg::EX_IDLE) &&
                     (((mode == `TEC_MODE_PROG) && rise) ||
                      ((mode == `TEC_MODE_PULSE) && rise) ||
                      ((mode != `TEC_MODE_FREE) && swtrig_q) ||
                      ((mode == `TEC_MODE_FREE) && !rd_busy));
  // Pulse mode ends on the trigger level, so a short pulse still ends
  assign exp_end = (ex_q == tec_pkg::EX_RUN) &&
                   ((mode == `TEC_MODE_PULSE) ? !trig_in
                                              : tmr_done);
  assign rd_start = (exp_end || (ex_q == tec_pkg::EX_HOLD)) && !rd_busy;
  assign tmr_load = (ex_d == tec_pkg::EX_DELAY && ex_q != tec_pkg::EX_DELAY)
                 || (ex_d == tec_pkg::EX_RUN && ex_q != tec_pkg::EX_RUN);
  assign tmr_val  = (ex_d == tec_pkg::EX_DELAY) ?
                    32'(`TEC_START_DLY_CYC) : exp_q;

  always_comb begin
    ex_d = ex_q;
    case (ex_q)
      tec_pkg::EX_IDLE:
        if (start_req)
          ex_d = video.fval ? tec_pkg::EX_ALIGN
                            : tec_pkg::EX_DELAY;
      tec_pkg::EX_ALIGN:
        if (lval_fall) ex_d = tec_pkg::EX_DELAY;
      tec_pkg::EX_DELAY:
        if (tmr_done) ex_d = tec_pkg::EX_RUN;
      tec_pkg::EX_RUN:
        if (exp_end)
          ex_d = rd_busy ? tec_pkg::EX_HOLD : tec_pkg::EX_IDLE;
      tec_pkg::EX_HOLD:
        if (!rd_busy) ex_d = tec_pkg::EX_IDLE;
      default: ex_d = tec_pkg::EX_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ex_q      <= tec_pkg::EX_IDLE;
      trig_q    <= 1'b0;
      lval_p_q  <= 1'b0;
      exp_act_q <= 32'h0000_0000;
    end else begin
      ex_q     <= ex_d;
      trig_q   <= trig_in;
      lval_p_q <= video.lval;
      // Value is frozen for the frame in flight
      if (tmr_load && ex_d == tec_pkg::EX_RUN) exp_act_q <= exp_q;
    end
  end

  assign exposing = (ex_q == tec_pkg::EX_RUN);

  tec_exp_timer #(.W(32)) u_timer (
    .mclk  (mclk),
    .rst_n (rst_n),
    .load  (tmr_load),
    .val   (tmr_val),
    .done  (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////
  // Readout framing; lines always run their full length
  logic [15:0] lines;
  logic [15:0] line_q;
  logic [15:0] col_q;
  logic [15:0] roi_first;

  assign roi_first = roi_q[15:0];
  assign lines     = (roi_q[31:16] == 16'h0000) ?
                     16'(SENSOR_ROWS) : roi_q[31:16];
  assign status    = {frames_q, 11'h000, ex_q == tec_pkg::EX_HOLD,
                      video.lval, video.fval, exposing, ex_q != tec_pkg::EX_IDLE};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q     <= tec_pkg::RD_IDLE;
      line_q   <= 16'h0000;
      col_q    <= 16'h0000;
      frames_q <= 16'h0000;
      video    <= '0;
    end else begin
      case (rd_q)
        tec_pkg::RD_IDLE:
          if (rd_start) begin
            rd_q   <= tec_pkg::RD_LINE;
            line_q <= 16'h0000;
            col_q  <= 16'h0000;
            video  <= '{fval: 1'b1, lval: 1'b1, row: roi_first};
          end
        tec_pkg::RD_LINE:
          if (col_q == 16'(LINE_CYC - 1)) begin
            rd_q       <= tec_pkg::RD_GAP;
            col_q      <= 16'h0000;
            video.lval <= 1'b0;
          end else begin
            col_q <= col_q + 16'h0001;
          end
        tec_pkg::RD_GAP:
          if (col_q != 16'(GAP_CYC - 1)) begin
            col_q <= col_q + 16'h0001;
          end else if (line_q == lines - 16'h0001) begin
            rd_q       <= tec_pkg::RD_IDLE;
            video.fval <= 1'b0;
            frames_q   <= frames_q + 16'h0001;
          end else begin
            rd_q       <= tec_pkg::RD_LINE;
            col_q      <= 16'h0000;
            line_q     <= line_q + 16'h0001;
            video.lval <= 1'b1;
            video.row  <= roi_first + line_q + 16'h0001;
          end
        default: rd_q <= tec_pkg::RD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic [15:0] dly_cnt_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) dly_cnt_q <= 16'h0000;
    else if (ex_q == tec_pkg::EX_DELAY) dly_cnt_q <= dly_cnt_q + 16'h0001;
    else dly_cnt_q <= 16'h0000;
  end

  logic [31:0] run_cnt_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) run_cnt_q <= 32'h0000_0000;
    else if (exposing) run_cnt_q <= run_cnt_q + 32'h0000_0001;
    else run_cnt_q <= 32'h0000_0000;
  end

  a_prog_edge_start: assert property (
    (ex_q == tec_pkg::EX_IDLE && en && mode == `TEC_MODE_PROG && rise &&
     !video.fval) |=> ex_q == tec_pkg::EX_DELAY)
    else $error("programmed trigger edge did not start delay");
  a_prog_len_end: assert property (
    (exposing && mode == `TEC_MODE_PROG && tmr_done) |=> !exposing)
    else $error("programmed exposure did not end on timer");
  a_align_on_lval: assert property (
    (ex_q == tec_pkg::EX_ALIGN && ex_d == tec_pkg::EX_DELAY) |->
    ($past(video.lval) && !video.lval))
    else $error("overlapped start not aligned to line-valid fall");
  a_noalign_idle: assert property (
    (start_req && !video.fval) |=> ex_q == tec_pkg::EX_DELAY)
    else $error("non-overlapped start did not go to delay");
  // Timed length must match the value latched at start, not the live one
  a_exp_frozen: assert property (
    (exp_end && mode != `TEC_MODE_PULSE) |->
    run_cnt_q + 32'h0000_0001 == ((exp_act_q == 32'h0000_0000) ?
                                  32'h0000_0001 : exp_act_q))
    else $error("active exposure changed mid exposure");
  a_nv_restore: assert property (
    (boot_q && nv_valid) |=> exp_q == $past(nv_exp))
    else $error("stored exposure not restored");
  a_sw_trig: assert property (
    (ex_q == tec_pkg::EX_IDLE && en && mode != `TEC_MODE_FREE && swtrig_q)
    |=> ex_q != tec_pkg::EX_IDLE)
    else $error("software trigger ignored");
  a_pulse_end: assert property (
    (exposing && mode == `TEC_MODE_PULSE && !trig_in) |=> !exposing)
    else $error("pulse exposure outlived trigger");
  a_lval_in_fval: assert property (
    video.lval |-> video.fval)
    else $error("line-valid outside frame-valid");
  a_dly_fixed: assert property (
    (ex_q == tec_pkg::EX_DELAY && ex_d == tec_pkg::EX_RUN) |->
    dly_cnt_q == 16'(`TEC_START_DLY_CYC - 1))
    else $error("start delay length varied");
  a_pulse_start: assert property (
    (ex_q == tec_pkg::EX_IDLE && en && mode == `TEC_MODE_PULSE && rise &&
     !video.fval) |=> ex_q == tec_pkg::EX_DELAY)
    else $error("pulse trigger edge did not start delay");
  a_exp_write: assert property (
    (wr_exp && !boot_q) |=> exp_q == $past(hwdata))
    else $error("exposure write not taken");
  a_frame_open: assert property (
    rd_start |=> video.fval && video.lval)
    else $error("readout did not open frame and line");
  a_line_close: assert property (
    (rd_q == tec_pkg::RD_LINE && col_q == 16'(LINE_CYC - 1)) |=> !video.lval)
    else $error("line did not close after full length");
  a_row_first: assert property (
    (rd_q == tec_pkg::RD_IDLE && rd_start) |=> video.row == $past(roi_first))
    else $error("readout did not open at first row");
endmodule // tec_top
`default_nettype wire

//--- core/tec_consts.svh
// Register map, field positions, reset values and timing constants
`ifndef TEC_CONSTS_SVH
`define TEC_CONSTS_SVH

`define TEC_CLK_MHZ      20
`define TEC_TICK_NS      15
`define TEC_START_DLY_NS 200
`define TEC_START_DLY_CYC \
  ((`TEC_START_DLY_NS * `TEC_CLK_MHZ + 999) / 1000)
`define TEC_EXP_MAX_S    60
`define TEC_EXP_MAX_CYC  (`TEC_EXP_MAX_S * `TEC_CLK_MHZ * 1000000)
`define TEC_EXP_RST_US   1000
`define TEC_EXP_RST_CYC  (`TEC_EXP_RST_US * `TEC_CLK_MHZ)

`define TEC_OFS_CTRL   8'h00
`define TEC_OFS_EXP    8'h04
`define TEC_OFS_SWTRIG 8'h08
`define TEC_OFS_ROI    8'h0c
`define TEC_OFS_STATUS 8'h10
`define TEC_OFS_NVCMD  8'h14

`define TEC_CTRL_MODE_LO 0
`define TEC_CTRL_MODE_HI 1
`define TEC_CTRL_EN      2
`define TEC_CTRL_RST     32'h0000_0000
`define TEC_ROI_RST      32'h0000_0000

`define TEC_MODE_FREE  2'h0
`define TEC_MODE_PULSE 2'h1
`define TEC_MODE_PROG  2'h2

`define TEC_HTRANS_NONSEQ 2'h2
`define TEC_HRESP_OKAY    1'h0

`endif

//--- core/tec_pkg.sv
// Types shared by the trigger and exposure control block
package tec_pkg;
  typedef struct packed {
    logic        fval;
    logic        lval;
    logic [15:0] row;
  } tec_video_t;

  typedef struct packed {
    logic        store;
    logic [31:0] data;
  } tec_nv_t;

  typedef enum logic [2:0] {
    EX_IDLE, EX_ALIGN, EX_DELAY, EX_RUN, EX_HOLD
  } tec_ex_state_t;

  typedef enum logic [1:0] {
    RD_IDLE, RD_LINE, RD_GAP
  } tec_rd_state_t;
endpackage

//--- core/tec_exp_timer.sv
// Loadable down-counter timing start delays and exposures
`timescale 1ns/10ps
`default_nettype none
module tec_exp_timer #(
  parameter int W = 32
) (
  input  wire logic         mclk,    // System clock
  input  wire logic         rst_n,   // Synchronised reset
  input  wire logic         load,    // Start a new interval
  input  wire logic [W-1:0] val,     // Interval in clock cycles
  output logic              done     // High in the interval's last cycle
);
  // The start delay alone needs three bits
  initial begin
    if (W < 3) $error("tec_exp_timer: counter too narrow");
  end

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         run_q;

  // A zero length still lasts one cycle
  assign cnt_d = load ? ((val == '0) ? W'(1) : val) : cnt_q - W'(1);
  assign done  = run_q && (cnt_q == W'(1));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else begin
      if (load || run_q) cnt_q <= cnt_d;
      if (load) run_q <= 1'b1;
      else if (done) run_q <= 1'b0;
    end
  end
endmodule // tec_exp_timer
`default_nettype wire

//--- dv/tec_far_end.sv
// Trigger source and frame grabber model at the block's far side
`timescale 1ns/10ps
`default_nettype none
module tec_far_end (
  input  wire logic                mclk,    // System clock
  input  wire tec_pkg::tec_video_t video,   // Framing seen by the grabber
  output logic                     trig_in  // Trigger line to the block
);
  logic late;
  initial trig_in = 1'b0;
  initial late = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // Pin trigger, preferred where the start time matters
  // Call right after a rising edge; pw holds the fall until frame ends
  task automatic pulse(input int w, input bit pw);
    int k;
    trig_in <= 1'b1;
    repeat (w) @(posedge mclk);
    for (k = 0; pw && video.fval && k < 500; k++) @(posedge mclk);
    if (k == 500) late = 1'b1;
    trig_in <= 1'b0;
  endtask
endmodule // tec_far_end
`default_nettype wire

//--- dv/tec_top_tb.sv
// Self-checking bench for the trigger and exposure block
`timescale 1ns/10ps
`default_nettype none
`include "tec_consts.svh"
module tec_top_tb;
  localparam int LN = 8;
  logic mclk, rstn, hsel, hwrite, hready, nv_valid, trig_in;
  logic hreadyout, hresp, exposing, pe, pt, fv;
  logic [31:0] haddr, hwdata, hrdata, nv_exp, rd, seed, x, q_nv[$];
  logic [1:0] htrans;
  logic [2:0] hsize;
  tec_pkg::tec_nv_t nv_out;
  tec_pkg::tec_video_t video;
  int failures, samples_checked, i, k, el, lw, lines, tc, dl, d0, nfr;
  int q_len[$], q_lines[$];

  tec_top #(.SENSOR_ROWS(4), .LINE_CYC(LN), .GAP_CYC(2),
    .EXP_RESET(32'h32)) tec_top_inst (.mclk(mclk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .trig_in(trig_in), .nv_valid(nv_valid), .nv_exp(nv_exp),
    .nv_out(nv_out), .exposing(exposing), .video(video));
  tec_far_end tec_far_end_inst (.mclk(mclk), .video(video),
    .trig_in(trig_in));
  assign hready = hreadyout;

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic tmo;
    failures++;
    $display("[ERR] wait expected end seen timeout");
    finish_test();
  endtask
  function automatic logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic sg(input int s);
    return s == 0 ? exposing : s == 1 ? video.fval : video.lval;
  endfunction
  task automatic till(input int s, input logic v);
    for (k = 0; k < 3000 && sg(s) !== v; k++) @(posedge mclk);
    if (k == 3000) tmo();
  endtask
  // Slave never stretches, yet every phase still waits for ready
  task automatic rdy;
    @(posedge mclk);
    for (k = 0; k < 50 && hreadyout !== 1'b1; k++) @(posedge mclk);
    if (k == 50) tmo();
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= `TEC_HTRANS_NONSEQ;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  task automatic rdr(input logic [7:0] a, input logic [31:0] e,
                     input string n);
    bus(1'b0, a, 32'h0);
    check(n, e, rd);
  endtask
  task automatic idle;
    // Lets a pending start delay run out before looking for quiet
    repeat (8) @(posedge mclk);
    till(0, 1'b0);
    repeat (3) @(posedge mclk);
    till(1, 1'b0);
    repeat (3) @(posedge mclk);
  endtask
  task automatic rst(input logic v, input logic [31:0] e);
    nv_valid <= v;
    nv_exp <= e;
    rstn <= 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  task automatic shot(input int n);
    q_len.push_back(n);
    q_lines.push_back(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Monitor: exposure length, line length, lines per frame, store data
  always @(posedge mclk) begin
    if (exposing === 1'b1) el++;
    else if (el > 0) begin
      if (q_len.size() > 0 && q_len[0] >= 0) check("exposure", q_len[0], el);
      if (q_len.size() > 0) void'(q_len.pop_front());
      el = 0;
    end
    if (video.lval === 1'b1) begin
      if (lw == 0) check("row", 32'(1 + lines), video.row);
      lw++;
    end else if (lw > 0) begin
      check("line", LN, lw);
      lines++;
      lw = 0;
    end
    if (video.fval === 1'b1) fv = 1'b1;
    else if (fv) begin
      check("lines", q_lines.size() ? q_lines.pop_front() : 0, lines);
      lines = 0;
      fv = 1'b0;
      nfr++;
    end
    if (nv_out.store === 1'b1) check("store", q_nv.pop_front(), nv_out.data);
    tc = (trig_in === 1'b1 && pt !== 1'b1) ? 0 : tc + 1;
    if (exposing === 1'b1 && pe !== 1'b1) dl = tc;
    pt = trig_in;
    pe = exposing;
  end

  initial begin
    rstn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, nv_exp, nv_valid} = '0;
    hsize = 3'h2;
    seed = 32'd47;
    {failures, samples_checked, el, lw, lines, tc, dl, d0, nfr} = '0;
    {pe, pt, fv} = '0;
    @(posedge mclk);
    rst(1'b1, 32'h1e);
    rdr(`TEC_OFS_EXP, 32'h1e, "nv exp");
    rdr(`TEC_OFS_CTRL, `TEC_CTRL_RST, "ctrl");
    rdr(`TEC_OFS_ROI, `TEC_ROI_RST, "roi");
    rdr(8'h40, 32'h0, "unmapped");
    rdr(`TEC_OFS_STATUS, 32'h0, "status idle");
    check("hresp", `TEC_HRESP_OKAY, hresp);
    bus(1'b1, `TEC_OFS_EXP, `TEC_EXP_MAX_CYC);
    rdr(`TEC_OFS_EXP, `TEC_EXP_MAX_CYC, "exp max");
    $display("test reset done");
    bus(1'b1, `TEC_OFS_ROI, 32'h0002_0001);
    bus(1'b1, `TEC_OFS_CTRL, 32'h6);
    for (i = 0; i < 4; i++) begin
      x = i == 0 ? 32'h0 : rnd() % 32 + 3;
      bus(1'b1, `TEC_OFS_EXP, x);
      shot(x == 0 ? 1 : int'(x));
      tec_far_end_inst.pulse(3, 1'b0);
      idle();
      if (i > 0) check("delay", d0, dl);
      d0 = dl;
    end
    check("delay bound", 1'b1, dl > 0 && dl < 9);
    $display("test programmed done");
    bus(1'b1, `TEC_OFS_EXP, 32'h28);
    shot(40);
    shot(12);
    tec_far_end_inst.pulse(3, 1'b0);
    till(0, 1'b1);
    bus(1'b1, `TEC_OFS_EXP, 32'hc);
    idle();
    bus(1'b1, `TEC_OFS_SWTRIG, 32'h1);
    idle();
    $display("test update and software trigger done");
    shot(12);
    shot(12);
    tec_far_end_inst.pulse(3, 1'b0);
    till(2, 1'b1);
    tec_far_end_inst.pulse(2, 1'b0);
    for (k = 0; k < 50 && video.lval === 1'b1; k++) begin
      if (exposing === 1'b1) check("early start", 1'b0, exposing);
      @(posedge mclk);
    end
    if (k == 50) tmo();
    for (k = 0; k < 50 && exposing !== 1'b1; k++) @(posedge mclk);
    check("align", 1'b1, k > 0 && k < 9);
    idle();
    $display("test overlap done");
    bus(1'b1, `TEC_OFS_CTRL, 32'h5);
    shot(-1);
    tec_far_end_inst.pulse(14, 1'b1);
    check("pulse open", 1'b1, exposing);
    for (k = 0; k < 9 && exposing === 1'b1; k++) @(posedge mclk);
    check("pulse close", 1'b1, k < 4);
    if (tec_far_end_inst.late === 1'b1) tmo();
    idle();
    $display("test pulse width done");
    shot(12);
    shot(12);
    bus(1'b1, `TEC_OFS_CTRL, 32'h4);
    till(1, 1'b1);
    till(1, 1'b0);
    till(1, 1'b1);
    bus(1'b1, `TEC_OFS_CTRL, 32'h0);
    idle();
    rdr(`TEC_OFS_STATUS, {16'(nfr), 16'h0000}, "status frames");
    $display("test free run done");
    q_nv.push_back(32'hc);
    bus(1'b1, `TEC_OFS_NVCMD, 32'h1);
    repeat (4) @(posedge mclk);
    check("store left", 0, q_nv.size());
    rst(1'b0, 32'h1e);
    rdr(`TEC_OFS_EXP, 32'h32, "exp default");
    $display("test store done");
    finish_test();
  end
endmodule // tec_top_tb
`default_nettype wire
